// ===== inc/rxc_pkg.sv
// Package of offsets, fields, reset values and codes for the receiver config registers
package rxc_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_RX_FILTER_BANDWIDTH   = 8'h10;
   localparam logic [7:0] IDX_POLYPHASE_CENTER      = 8'h11;
   localparam logic [7:0] IDX_SYNC_AND_BITSYNC_CTRL = 8'h12;
   localparam logic [7:0] IDX_OOK_THRESHOLD_FLOOR   = 8'h13;
   localparam logic [7:0] IDX_SIGNAL_STRENGTH_VALUE = 8'h14;
   localparam logic [7:0] IDX_OOK_THRESHOLD_DYN     = 8'h15;
   localparam logic [7:0] IDX_SYNC_PATTERN_0        = 8'h16;
   localparam logic [7:0] IDX_SYNC_PATTERN_1        = 8'h17;
   localparam logic [7:0] IDX_SYNC_PATTERN_2        = 8'h18;
   localparam logic [7:0] IDX_SYNC_PATTERN_3        = 8'h19;
   localparam logic [7:0] IDX_DEMOD_STATUS          = 8'h1a;
   localparam logic [7:0] IDX_FIFO_FILL_CTRL        = 8'h1b;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_PASSIVE_LP   = 4;
   localparam int POS_RX_BW        = 0;
   localparam int POS_POLY_CENTER  = 4;
   localparam int POS_POLY_EN      = 7;
   localparam int POS_BITSYNC_OFF  = 6;
   localparam int POS_SYNC_EN      = 5;
   localparam int POS_SYNC_LEN     = 3;
   localparam int POS_SYNC_TOL     = 1;
   localparam int POS_DEC_STEP     = 5;
   localparam int POS_DEC_RATE     = 2;
   localparam int POS_AVG_CUTOFF   = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_RX_FILTER_BANDWIDTH = 8'ha3;
   localparam logic [7:0] RST_POLYPHASE_CENTER    = 8'h38;
   localparam logic [7:0] RST_SYNC_CTRL           = 8'h18;
   localparam logic [7:0] RST_OOK_FLOOR           = 8'h04;
   localparam logic [7:0] RST_OOK_DYN             = 8'h00;
   localparam logic [7:0] RST_SYNC_PATTERN        = 8'h00;

   // ----------------------------------------------------------------
   // Codes and bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] AVG_CUTOFF_SLOW = 2'h3;
   localparam logic [1:0] AXI_OKAY        = 2'h0;
   localparam logic [1:0] AXI_SLVERR      = 2'h2;

   typedef enum logic [1:0] {
      RXC_TH_FIXED   = 2'b00,
      RXC_TH_PEAK    = 2'b01,
      RXC_TH_AVERAGE = 2'b10
   } rxc_thresh_mode_e;
endpackage

// ===== hw/rxc_sync_detect.sv
// Sync pattern correlator with error tolerance
`timescale 1ns/1ns
module rxc_sync_detect
   import rxc_pkg::*;
#(
   parameter int MAX_BITS = 32
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // Settings
   input  wire logic        sync_en,
   input  wire logic [1:0]  sync_len,
   input  wire logic [1:0]  sync_tol,
   input  wire logic [31:0] pattern,
   // Bit stream
   input  wire logic        bit_valid,
   input  wire logic        bit_data,
   // Result
   output logic             match
);
   if (MAX_BITS != 32) begin : g_width_check
      $error("rxc_sync_detect supports 32 bits only");
   end

   logic [31:0] shift_r;
   logic [31:0] win;
   logic [31:0] diff;
   logic [31:0] mask;
   logic [5:0]  errs;
   logic [5:0]  seen_r;

   // Newest bit enters at bit 0; byte one of the pattern is the oldest
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_r <= 32'h0;
         seen_r  <= 6'h0;
      end else if (clk_en && bit_valid) begin
         shift_r <= {shift_r[30:0], bit_data};
         if (seen_r != 6'h20) seen_r <= seen_r + 6'h1;
      end
   end

   // The arriving bit belongs to the window judged at this edge
   assign win = {shift_r[30:0], bit_data};

   // Pattern bytes are used in order; only the leading bytes take part
   always_comb begin
      logic [31:0] pat;
      pat  = 32'h0;
      mask = 32'h0;
      case (sync_len)
         2'b00:   begin pat = {24'h0, pattern[31:24]}; mask = 32'h0000_00ff; end
         2'b01:   begin pat = {16'h0, pattern[31:16]}; mask = 32'h0000_ffff; end
         2'b10:   begin pat = {8'h0, pattern[31:8]};   mask = 32'h00ff_ffff; end
         default: begin pat = pattern;                 mask = 32'hffff_ffff; end
      endcase
      diff = (win ^ pat) & mask;
      errs = 6'h0;
      for (int i = 0; i < 32; i++) begin
         errs = errs + {5'h0, diff[i]};
      end
   end

   // Match only once enough bits have arrived to fill the window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match <= 1'b0;
      end else if (clk_en) begin
         match <= sync_en && bit_valid && (seen_r >= {1'b0, sync_len, 3'h7})
                  && (errs <= {4'h0, sync_tol});
      end
   end
endmodule // rxc_sync_detect

// ===== hw/rxc_regs.sv
// Receiver configuration register bank with AXI4-Lite slave and OOK threshold engine
`timescale 1ns/1ns
module rxc_regs
   import rxc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              clk_en,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Demodulator inputs
   input  wire logic [7:0]        rssi_in,
   input  wire logic              rx_bit_valid,
   input  wire logic              rx_bit,
   input  wire logic              chip_tick,
   input  wire logic              sub_tick,
   input  wire logic              ook_peak,
   input  wire logic              ook_mode,
   input  wire logic              continuous_mode,
   input  wire logic              buffered_mode,
   input  wire logic              fifo_auto_fill,
   // Analog and demodulator controls
   output logic [3:0]             passive_lowpass_code,
   output logic [3:0]             rx_bandwidth_code,
   output logic [3:0]             polyphase_center_code,
   output logic                   polyphase_enable,
   output logic                   bitsync_enable,
   output logic [1:0]             ook_average_cutoff,
   output logic [7:0]             ook_threshold,
   output logic                   sync_match,
   output logic                   fifo_fill_start
);
   if (ADDR_W < 8) begin : g_addr_check
      $error("rxc_regs needs at least 8 address bits");
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] bw_r;
   logic [7:0] poly_r;
   logic [7:0] sync_r;
   logic [7:0] floor_r;
   logic [7:0] rssi_r;
   logic [7:0] dyn_r;
   logic [7:0] pat_r [4];
   logic       fill_active_r;
   logic       match_seen_r;
   logic [7:0] thresh_r;
   logic [3:0] rate_cnt_r;

   // Word index from a byte address; bits above the word are ignored
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] s;
      s = a >> 2;
      return {2'b00, s[5:0]};
   endfunction

   // Byte step in half-dB units: 1..4, then 6,8,10,12
   function automatic logic [7:0] step_units(input logic [2:0] c);
      return c[2] ? {5'h0, c[1:0], 1'b0} + 8'h6 : {6'h0, c[1:0]} + 8'h1;
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic              aw_held_r;
   logic              w_held_r;
   logic [7:0]        aw_idx_r;
   logic [7:0]        wdata_r;
   logic              wstb_r;
   logic              do_write;
   logic              wr_ok;

   // Address and data may come in either order; each is held once taken
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_idx_r  <= 8'h0;
         wdata_r   <= 8'h0;
         wstb_r    <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= word_idx(s_axi_awaddr);
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wstb_r   <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Writable indices; the strength and status words refuse writes
   always_comb begin
      case (aw_idx_r)
         IDX_RX_FILTER_BANDWIDTH, IDX_POLYPHASE_CENTER, IDX_SYNC_AND_BITSYNC_CTRL,
         IDX_OOK_THRESHOLD_FLOOR, IDX_OOK_THRESHOLD_DYN, IDX_SYNC_PATTERN_0,
         IDX_SYNC_PATTERN_1, IDX_SYNC_PATTERN_2, IDX_SYNC_PATTERN_3,
         IDX_FIFO_FILL_CTRL: wr_ok = 1'b1;
         default:            wr_ok = 1'b0;
      endcase
   end

   // Response follows the write by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bw_r    <= RST_RX_FILTER_BANDWIDTH;
         poly_r  <= RST_POLYPHASE_CENTER;
         sync_r  <= RST_SYNC_CTRL;
         floor_r <= RST_OOK_FLOOR;
         dyn_r   <= RST_OOK_DYN;
         for (int i = 0; i < 4; i++) pat_r[i] <= RST_SYNC_PATTERN;
      end else if (clk_en && do_write && wstb_r) begin
         case (aw_idx_r)
            IDX_RX_FILTER_BANDWIDTH:   bw_r     <= wdata_r;
            IDX_POLYPHASE_CENTER:      poly_r   <= wdata_r;
            IDX_SYNC_AND_BITSYNC_CTRL: sync_r   <= wdata_r;
            IDX_OOK_THRESHOLD_FLOOR:   floor_r  <= wdata_r;
            IDX_OOK_THRESHOLD_DYN:     dyn_r    <= wdata_r;
            IDX_SYNC_PATTERN_0:        pat_r[0] <= wdata_r;
            IDX_SYNC_PATTERN_1:        pat_r[1] <= wdata_r;
            IDX_SYNC_PATTERN_2:        pat_r[2] <= wdata_r;
            IDX_SYNC_PATTERN_3:        pat_r[3] <= wdata_r;
            default: ;
         endcase
      end
   end

   // Strength is sampled every enabled cycle; software sees the latest value
   always_ff @(posedge aclk) begin
      if (!aresetn) rssi_r <= 8'h0;
      else if (clk_en) rssi_r <= rssi_in;
   end

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   assign passive_lowpass_code  = bw_r[POS_PASSIVE_LP +: 4];
   assign rx_bandwidth_code     = bw_r[POS_RX_BW +: 4];
   assign polyphase_center_code = poly_r[POS_POLY_CENTER +: 4];
   assign polyphase_enable      = ook_mode && sync_r[POS_POLY_EN];
   // Outside continuous mode the synchronizer is left running
   assign bitsync_enable = !(continuous_mode && sync_r[POS_BITSYNC_OFF]);
   assign ook_average_cutoff    = dyn_r[POS_AVG_CUTOFF +: 2];
   assign ook_threshold         = thresh_r;

   // ----------------------------------------------------------------
   // Sync detector
   // ----------------------------------------------------------------
   rxc_sync_detect #(.MAX_BITS(32)) u_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clk_en    (clk_en),
      .sync_en   (sync_r[POS_SYNC_EN]),
      .sync_len  (sync_r[POS_SYNC_LEN +: 2]),
      .sync_tol  (sync_r[POS_SYNC_TOL +: 2]),
      .pattern   ({pat_r[0], pat_r[1], pat_r[2], pat_r[3]}),
      .bit_valid (rx_bit_valid),
      .bit_data  (rx_bit),
      .match     (sync_match)
   );

   // Automatic fill: a match starts filling; software writes 1 to rearm.
   // A fill start wins over a rearm write in the same cycle, and a match wins over it for the seen flag.
   logic rearm;
   assign rearm = do_write && wstb_r && (aw_idx_r == IDX_FIFO_FILL_CTRL) && wdata_r[0];
   assign fifo_fill_start = buffered_mode && fifo_auto_fill && sync_match
                            && !fill_active_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fill_active_r <= 1'b0;
         match_seen_r  <= 1'b0;
      end else if (clk_en) begin
         if (fifo_fill_start) fill_active_r <= 1'b1;
         else if (rearm) fill_active_r <= 1'b0;
         if (sync_match) match_seen_r <= 1'b1;
         else if (rearm) match_seen_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // OOK peak threshold decay
   // ----------------------------------------------------------------
   // Slow rates count chip ticks; fast rates count sub-chip ticks (16 per chip)
   logic       dec_tick;
   logic [2:0] rate;
   logic [3:0] rate_lim;
   assign rate = dyn_r[POS_DEC_RATE +: 3];

   always_comb begin
      case (rate)
         3'b000:  rate_lim = 4'h0;
         3'b001:  rate_lim = 4'h1;
         3'b010:  rate_lim = 4'h3;
         3'b011:  rate_lim = 4'h7;
         3'b100:  rate_lim = 4'h7;
         3'b101:  rate_lim = 4'h3;
         3'b110:  rate_lim = 4'h1;
         default: rate_lim = 4'h0;
      endcase
   end

   // Counter of the tick source chosen by the rate code
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_cnt_r <= 4'h0;
      end else if (clk_en && (rate[2] ? sub_tick : chip_tick)) begin
         rate_cnt_r <= (rate_cnt_r >= rate_lim) ? 4'h0 : rate_cnt_r + 4'h1;
      end
   end
   assign dec_tick = (rate[2] ? sub_tick : chip_tick) && (rate_cnt_r >= rate_lim);

   // A borrow into bit 8 means the step would pass below zero
   logic [8:0] dropped;
   assign dropped = {1'b0, thresh_r} - {1'b0, step_units(dyn_r[POS_DEC_STEP +: 3])};

   // Peak captures the signal level; decay clamps at the floor
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thresh_r <= RST_OOK_FLOOR;
      end else if (clk_en) begin
         if (!ook_peak) begin
            thresh_r <= floor_r;
         end else if (rssi_r > thresh_r) begin
            thresh_r <= rssi_r;
         end else if (dec_tick) begin
            if (dropped[8] || dropped[7:0] < floor_r) thresh_r <= floor_r;
            else thresh_r <= dropped[7:0];
         end else if (thresh_r < floor_r) begin
            thresh_r <= floor_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [7:0] rd_val;
   logic       rd_ok;

   always_comb begin
      rd_ok = 1'b1;
      case (word_idx(s_axi_araddr))
         IDX_RX_FILTER_BANDWIDTH:   rd_val = bw_r;
         IDX_POLYPHASE_CENTER:      rd_val = poly_r;
         IDX_SYNC_AND_BITSYNC_CTRL: rd_val = sync_r;
         IDX_OOK_THRESHOLD_FLOOR:   rd_val = floor_r;
         IDX_SIGNAL_STRENGTH_VALUE: rd_val = rssi_r;
         IDX_OOK_THRESHOLD_DYN:     rd_val = dyn_r;
         IDX_SYNC_PATTERN_0:        rd_val = pat_r[0];
         IDX_SYNC_PATTERN_1:        rd_val = pat_r[1];
         IDX_SYNC_PATTERN_2:        rd_val = pat_r[2];
         IDX_SYNC_PATTERN_3:        rd_val = pat_r[3];
         IDX_DEMOD_STATUS:          rd_val = thresh_r;
         IDX_FIFO_FILL_CTRL:        rd_val = {6'h0, match_seen_r, fill_active_r};
         default: begin
            rd_val = 8'h0;
            rd_ok  = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= AXI_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_val};
            s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // rxc_regs

// ===== sim/rxc_regs_properties.sv
// Concurrent checks on the receiver config register ports
`timescale 1ns/1ns
module rxc_regs_properties (
   // Clock and reset
   input logic        aclk, aresetn, clk_en,
   // Bus handshakes
   input logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input logic [31:0] s_axi_rdata,
   // Modes and results
   input logic        ook_mode, continuous_mode, polyphase_enable, bitsync_enable,
   input logic        rx_bit_valid, sync_match, fifo_fill_start, buffered_mode,
   input logic        fifo_auto_fill
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answers stand until the master takes them
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
      |=> s_axi_rvalid) else $error("read answer late");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   // Mode gating of the filter and synchronizer controls
   a_poly_ook_only: assert property (!ook_mode |-> !polyphase_enable)
      else $error("polyphase on outside ook");
   a_bitsync_block: assert property (!continuous_mode |-> bitsync_enable)
      else $error("bitsync off outside continuous");
   // A match needs a fresh bit, a fill start needs a match
   a_match_cause: assert property (sync_match |-> $past(rx_bit_valid) ||
      $past(rx_bit_valid, 2)) else $error("match without bit");
   a_fill_cause: assert property (fifo_fill_start |-> sync_match &&
      buffered_mode && fifo_auto_fill) else $error("fill start without cause");
endmodule // rxc_regs_properties

// ===== sim/tb_top.sv
// Self-checking bench for the receiver config register bank
`timescale 1ns/1ns
module tb_top;
   import rxc_pkg::*;
   logic aclk = 0, aresetn = 0, clk_en = 1, chip_tick = 0, sub_tick = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rssi_in = 8'h5a;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, passive_lowpass_code, rx_bandwidth_code;
   logic [3:0] polyphase_center_code;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, rx_bit_valid = 0, rx_bit = 0, ook_peak = 0, ook_mode = 0;
   logic continuous_mode = 0, buffered_mode = 1, fifo_auto_fill = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic polyphase_enable, bitsync_enable, sync_match, fifo_fill_start;
   logic [1:0] s_axi_bresp, s_axi_rresp, ook_average_cutoff;
   logic [7:0] ook_threshold;
   int fails = 0, cmp_count = 0;

   rxc_regs u_rxc_regs (.*);

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic limit(input int n);
      if (n >= 60) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [7:0] ba(input logic [7:0] i);
      return {i[5:0], 2'b00};
   endfunction
   // Both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 60);
      limit(n);
      s_axi_bready <= 1'b0;
      chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 60);
      limit(n);
      s_axi_rready <= 1'b0;
      chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
      chk($sformatf("rdata %h", a), ed, s_axi_rdata);
   endtask
   task automatic tick();
      chip_tick <= 1'b1;
      @(posedge aclk);
      chip_tick <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      @(posedge aclk);
      chk("codes", 32'ha330_0000, {passive_lowpass_code, rx_bandwidth_code,
         polyphase_center_code, 4'h0, 16'h0000});
      chk("gates", 32'h1, 32'({polyphase_enable, bitsync_enable}));
      chk("threshold", 32'h04, 32'(ook_threshold));
      rd(8'h40, 32'ha3, AXI_OKAY);
      rd(8'h44, 32'h38, AXI_OKAY);
      rd(8'h48, 32'h18, AXI_OKAY);
      rd(8'h4c, 32'h04, AXI_OKAY);
      rd(8'h54, 32'h00, AXI_OKAY);
      rd(8'h50, 32'h5a, AXI_OKAY);
      wr(8'h50, 8'h11, AXI_SLVERR);
      rd(8'h50, 32'h5a, AXI_OKAY);
      rd(8'hfc, 32'h0, AXI_SLVERR);
      wr(8'hf0, 8'h11, AXI_SLVERR);
   endtask
   task automatic t_modes();
      wr(8'h48, 8'hc0, AXI_OKAY);
      wr(8'h54, 8'he3, AXI_OKAY);
      wr(8'h40, 8'h5c, AXI_OKAY);
      wr(8'h44, 8'h7f, AXI_OKAY);
      ook_mode <= 1'b1;
      continuous_mode <= 1'b1;
      @(posedge aclk);
      @(posedge aclk);
      chk("gates on", 32'h2, 32'({polyphase_enable, bitsync_enable}));
      chk("cutoff", 32'h3, 32'(ook_average_cutoff));
      chk("codes", 32'h5c7, {20'h0, passive_lowpass_code, rx_bandwidth_code,
         polyphase_center_code});
      rd(8'h54, 32'he3, AXI_OKAY);
      wr(8'h48, 8'h00, AXI_OKAY);
      @(posedge aclk);
      chk("gates off", 32'h1, 32'({polyphase_enable, bitsync_enable}));
      ook_mode <= 1'b0;
      continuous_mode <= 1'b0;
   endtask
   // Peak threshold rises with signal, decays in steps, stops at the floor.
   // The strength is settled before peak mode starts, so no stale peak is caught.
   task automatic t_thresh();
      rssi_in <= 8'h30;
      wr(8'h4c, 8'h20, AXI_OKAY);
      wr(8'h54, 8'he0, AXI_OKAY);
      chk("fixed", 32'h20, 32'(ook_threshold));
      ook_peak <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("peak", 32'h30, 32'(ook_threshold));
      rssi_in <= 8'h10;
      tick();
      chk("step 6 dB", 32'h24, 32'(ook_threshold));
      tick();
      chk("floor", 32'h20, 32'(ook_threshold));
      wr(8'h54, 8'h04, AXI_OKAY);
      rssi_in <= 8'h30;
      repeat (4) @(posedge aclk);
      rssi_in <= 8'h10;
      tick();
      tick();
      chk("every 2 chips", 32'h2f, 32'(ook_threshold));
      ook_peak <= 1'b0;
   endtask
   // A low enable must hold the threshold, a high one must let it run again
   task automatic t_freeze();
      clk_en <= 1'b0;
      rssi_in <= 8'h66;
      ook_peak <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("frozen", 32'h20, 32'(ook_threshold));
      clk_en <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("thawed", 32'h66, 32'(ook_threshold));
      ook_peak <= 1'b0;
   endtask
   task automatic t_sync();
      logic [7:0] ctl[8] = '{8'h20, 8'h20, 8'h22, 8'h00, 8'h26, 8'h26, 8'h28, 8'h28};
      logic [15:0] pat[8] = '{16'ha5, 16'ha4, 16'ha4, 16'ha5, 16'ha2, 16'haa, 16'ha53c,
         16'h3c};
      logic exp[8] = '{1, 0, 1, 0, 1, 0, 1, 0};
      logic hit, fs;
      wr(8'h58, 8'ha5, AXI_OKAY);
      wr(8'h5c, 8'h3c, AXI_OKAY);
      for (int k = 0; k < 8; k++) begin
         wr(8'h48, ctl[k], AXI_OKAY);
         hit = 1'b0;
         fs = 1'b0;
         // Oldest bit first so the pattern ends at the newest bit; the rearm
         // comes before the last bit, so a partial window that already
         // matched cannot hide the fill start of the full one
         for (int i = (ctl[k][3] ? 15 : 7); i >= 0; i--) begin
            if (i == 0) begin
               @(posedge aclk);
               rx_bit_valid <= 1'b0;
               wr(8'h6c, 8'h01, AXI_OKAY);
            end
            @(posedge aclk);
            rx_bit <= pat[k][i];
            rx_bit_valid <= 1'b1;
         end
         @(posedge aclk);
         rx_bit_valid <= 1'b0;
         repeat (3) begin
            @(posedge aclk);
            hit |= sync_match;
            fs |= fifo_fill_start;
         end
         chk("match", 32'(exp[k]), 32'(hit));
         chk("fill start", 32'(exp[k]), 32'(fs));
      end
   endtask

   initial begin
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_modes();
      t_thresh();
      t_sync();
      t_freeze();
      conclude();
   end
endmodule // tb_top

bind rxc_regs rxc_regs_properties u_rxc_regs_properties (.*);
